// ---- src/dmau_core.sv ----
// Data memory addressing unit: pointers, bank select, accumulator, table and map logic
`timescale 1ns/1ns
module dmau_core #(
  parameter int PAGE_W      = dmau_pkg::PAGE_W_DEF,
  parameter int MAP_PERIODS = dmau_pkg::MAP_LOW_SPEED_INTERNAL_OSC_PERIODS
) (
  input  wire logic                           mclk_i,
  input  wire logic                           reset_n_i,
  input  wire logic                           soft_rst_i,
  input  wire logic                           wake_i,
  input  wire logic                           instr_cycle_i,
  input  wire logic                           low_speed_internal_osc_tick_i,
  input  wire dmau_pkg::dmau_req_t            req_i,
  output logic [7:0]                          rdata_o,
  output logic                                rvalid_o,
  input  wire logic                           alu_we_i,
  input  wire logic [7:0]                     alu_result_i,
  output logic [7:0]                          acc_o,
  input  wire logic [7:0]                     pc_low_i,
  output logic                                pc_load_o,
  output logic [7:0]                          pc_low_o,
  output logic                                dummy_cycle_o,
  input  wire logic                           tbl_last_page_i,
  output logic                                pm_rd_o,
  output logic [PAGE_W+7:0]                   pm_addr_o,
  input  wire logic [dmau_pkg::PM_DW-1:0]     pm_data_i,
  output logic                                opt_rd_o,
  output logic [dmau_pkg::OPT_AW-1:0]         opt_addr_o,
  input  wire logic [dmau_pkg::PM_DW-1:0]     opt_data_i,
  output dmau_pkg::dmau_mem_t                 mem_o,
  input  wire logic [7:0]                     mem_rdata_i,
  output logic                                map_active_o,
  output logic                                bank_select_bit_o
);

  // ----------------------------------------------------------------------
  // Address helpers
  // ----------------------------------------------------------------------
  function automatic logic is_virtual(input logic [7:0] a);
    return (a == dmau_pkg::ADDR_IND_A) || (a == dmau_pkg::ADDR_IND_B);
  endfunction : is_virtual

  // Map an operand address to the location really touched
  function automatic dmau_pkg::dmau_loc_t resolve(input logic [7:0] a,
                                                  input logic [7:0] pa,
                                                  input logic [7:0] pb,
                                                  input logic       bank);
    dmau_pkg::dmau_loc_t l;
    l.bank = dmau_pkg::BANK_RST;
    l.addr = a;
    l.nul  = 1'b0;
    if (a == dmau_pkg::ADDR_IND_A) begin
      l.addr = pa;
      l.nul  = is_virtual(pa);
    end else if (a == dmau_pkg::ADDR_IND_B) begin
      l.bank = bank;
      l.addr = pb;
      l.nul  = is_virtual(pb);
    end
    return l;
  endfunction : resolve

  function automatic logic is_local(input dmau_pkg::dmau_loc_t l);
    logic hit;
    hit = 1'b0;
    if (l.bank == dmau_pkg::BANK_RST) begin
      case (l.addr)
        dmau_pkg::ADDR_PTR_A, dmau_pkg::ADDR_PTR_B, dmau_pkg::ADDR_BANK,
        dmau_pkg::ADDR_ACC, dmau_pkg::ADDR_PCLO, dmau_pkg::ADDR_TPLO,
        dmau_pkg::ADDR_THB, dmau_pkg::ADDR_TPHI, dmau_pkg::ADDR_UNLOCK: hit = 1'b1;
        default: hit = 1'b0;
      endcase
    end
    return hit;
  endfunction : is_local

  // ----------------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------------
  logic [7:0]        ptr_a_q, ptr_a_d, ptr_b_q, ptr_b_d;
  logic              bank_q, bank_d;
  logic [7:0]        acc_q, acc_d;
  logic [7:0]        tplo_q, tplo_d, thb_q, thb_d;
  logic [PAGE_W-1:0] tphi_q, tphi_d;
  logic [7:0]        unlock_q, unlock_d;
  logic              armed_q, armed_d;
  logic [7:0]        rdata_q, rdata_d;
  logic              rvalid_q, rvalid_d;
  logic              pc_load_q, pc_load_d;
  logic [7:0]        pc_low_q, pc_low_d;

  // ----------------------------------------------------------------------
  // Access decode
  // ----------------------------------------------------------------------
  dmau_pkg::dmau_loc_t        loc;
  logic                       local_hit, wr_en, rd_en, unlock_wr, unlock_ok;
  logic [PAGE_W-1:0]          page;
  logic                       opt_hit;
  logic [dmau_pkg::PM_DW-1:0] tword;
  logic [7:0]                 wbyte, local_rdata;

  // Every transfer lands in a memory location or the accumulator; there is
  // no path that copies one data memory location straight into another
  always_comb begin
    loc       = resolve(req_i.addr, ptr_a_q, ptr_b_q, bank_q);
    local_hit = is_local(loc);
    wr_en     = req_i.valid && (req_i.we || req_i.tbl) && !loc.nul;
    rd_en     = req_i.valid && !req_i.we && !req_i.tbl;
    page      = tbl_last_page_i ? '1 : tphi_q;
    opt_hit   = map_active_o && (page == '1) &&
                (tplo_q[7:5] == dmau_pkg::OPT_WIN_TOP);
    tword     = opt_hit ? opt_data_i : pm_data_i;
    wbyte     = req_i.tbl ? tword[7:0] : req_i.wdata;
    unlock_wr = wr_en && local_hit && (loc.addr == dmau_pkg::ADDR_UNLOCK);
    unlock_ok = instr_cycle_i && armed_q && unlock_wr &&
                (wbyte == dmau_pkg::UNLOCK_SECOND);
  end

  // Local read mux; unimplemented bank bits read as zero
  always_comb begin
    local_rdata = dmau_pkg::BYTE_ZERO;
    case (loc.addr)
      dmau_pkg::ADDR_PTR_A:  local_rdata = ptr_a_q;
      dmau_pkg::ADDR_PTR_B:  local_rdata = ptr_b_q;
      dmau_pkg::ADDR_BANK:   local_rdata = {7'h00, bank_q};
      dmau_pkg::ADDR_ACC:    local_rdata = acc_q;
      dmau_pkg::ADDR_PCLO:   local_rdata = pc_low_i;
      dmau_pkg::ADDR_TPLO:   local_rdata = tplo_q;
      dmau_pkg::ADDR_THB:    local_rdata = thb_q;
      dmau_pkg::ADDR_TPHI:   local_rdata = 8'(tphi_q);
      dmau_pkg::ADDR_UNLOCK: local_rdata = unlock_q;
      default:               local_rdata = dmau_pkg::BYTE_ZERO;
    endcase
  end

  // ----------------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------------
  always_comb begin
    ptr_a_d   = ptr_a_q;
    ptr_b_d   = ptr_b_q;
    bank_d    = bank_q;
    acc_d     = acc_q;
    tplo_d    = tplo_q;
    thb_d     = thb_q;
    tphi_d    = tphi_q;
    unlock_d  = unlock_q;
    armed_d   = armed_q;
    pc_load_d = 1'b0;
    pc_low_d  = pc_low_q;
    if (wr_en && local_hit) begin
      case (loc.addr)
        dmau_pkg::ADDR_PTR_A:  ptr_a_d = wbyte;
        dmau_pkg::ADDR_PTR_B:  ptr_b_d = wbyte;
        dmau_pkg::ADDR_BANK:   bank_d = wbyte[0];
        dmau_pkg::ADDR_ACC:    acc_d = wbyte;
        dmau_pkg::ADDR_PCLO: begin
          pc_load_d = 1'b1;
          pc_low_d  = wbyte;
        end
        dmau_pkg::ADDR_TPLO:   tplo_d = wbyte;
        dmau_pkg::ADDR_THB:    thb_d = wbyte;
        dmau_pkg::ADDR_TPHI:   tphi_d = wbyte[PAGE_W-1:0];
        dmau_pkg::ADDR_UNLOCK: unlock_d = wbyte;
        default:               acc_d = acc_q;
      endcase
    end
    // ALU result takes the accumulator over a same-cycle operand write
    if (alu_we_i) begin
      acc_d = alu_result_i;
    end
    // High byte goes last so it wins when the operand is the high byte itself
    if (req_i.valid && req_i.tbl) begin
      thb_d = tword[15:8];
    end
    // A 55H arms only the very next instruction cycle
    if (instr_cycle_i) begin
      armed_d = unlock_wr && (wbyte == dmau_pkg::UNLOCK_FIRST);
    end
    if (wake_i) begin
      unlock_d = dmau_pkg::BYTE_ZERO;
      armed_d  = 1'b0;
    end
    // Idle watchdog reset does not raise soft_rst_i, so the bank is kept
    if (soft_rst_i) begin
      bank_d = dmau_pkg::BANK_RST;
    end
  end

  // Read answer is registered one cycle after the request
  always_comb begin
    rvalid_d = rd_en;
    rdata_d  = rdata_q;
    if (rd_en) begin
      if (loc.nul) begin
        rdata_d = dmau_pkg::BYTE_ZERO;
      end else if (local_hit) begin
        rdata_d = local_rdata;
      end else begin
        rdata_d = mem_rdata_i;
      end
    end
  end

  // State registers
  always_ff @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      ptr_a_q   <= dmau_pkg::BYTE_ZERO;
      ptr_b_q   <= dmau_pkg::BYTE_ZERO;
      bank_q    <= dmau_pkg::BANK_RST;
      acc_q     <= dmau_pkg::BYTE_ZERO;
      tplo_q    <= dmau_pkg::BYTE_ZERO;
      thb_q     <= dmau_pkg::BYTE_ZERO;
      tphi_q    <= '0;
      unlock_q  <= dmau_pkg::BYTE_ZERO;
      armed_q   <= 1'b0;
      rdata_q   <= dmau_pkg::BYTE_ZERO;
      rvalid_q  <= 1'b0;
      pc_load_q <= 1'b0;
      pc_low_q  <= dmau_pkg::BYTE_ZERO;
    end else begin
      ptr_a_q   <= ptr_a_d;
      ptr_b_q   <= ptr_b_d;
      bank_q    <= bank_d;
      acc_q     <= acc_d;
      tplo_q    <= tplo_d;
      thb_q     <= thb_d;
      tphi_q    <= tphi_d;
      unlock_q  <= unlock_d;
      armed_q   <= armed_d;
      rdata_q   <= rdata_d;
      rvalid_q  <= rvalid_d;
      pc_load_q <= pc_load_d;
      pc_low_q  <= pc_low_d;
    end
  end

  // ----------------------------------------------------------------------
  // Mapping window timer
  // ----------------------------------------------------------------------
  dmau_map_timer #(
    .PERIODS (MAP_PERIODS)
  ) u_timer (
    .mclk_i      (mclk_i),
    .reset_n_i   (reset_n_i),
    .start_i     (unlock_ok),
    .low_speed_internal_osc_tick_i (low_speed_internal_osc_tick_i),
    .active_o    (map_active_o)
  );

  // ----------------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------------
  // Memory port only sees accesses that escape the local registers
  assign mem_o.req   = req_i.valid && !loc.nul && !local_hit && (rd_en || wr_en);
  assign mem_o.we    = wr_en && !local_hit;
  assign mem_o.bank  = loc.bank;
  assign mem_o.addr  = loc.addr;
  assign mem_o.wdata = wbyte;

  // Program or option memory fetch for table reads
  assign pm_rd_o    = req_i.valid && req_i.tbl && !opt_hit;
  assign pm_addr_o  = {page, tplo_q};
  assign opt_rd_o   = req_i.valid && req_i.tbl && opt_hit;
  assign opt_addr_o = tplo_q[dmau_pkg::OPT_AW-1:0];

  // Only the low byte is loaded; the executor keeps its page bits
  assign pc_load_o         = pc_load_q;
  assign pc_low_o          = pc_low_q;
  assign dummy_cycle_o     = pc_load_q;
  assign rdata_o           = rdata_q;
  assign rvalid_o          = rvalid_q;
  assign acc_o             = acc_q;
  assign bank_select_bit_o = bank_q;

  // ----------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!reset_n_i);

  property p_ind_b_bank;
    req_i.valid && (req_i.addr == dmau_pkg::ADDR_IND_B) && mem_o.req |-> mem_o.bank == bank_q
      && mem_o.addr == ptr_b_q;
  endproperty
  a_ind_b_bank: assert property (p_ind_b_bank) else $error("Pointer b access wrong");

  property p_direct_bank0;
    req_i.valid && !is_virtual(req_i.addr) && mem_o.req |-> !mem_o.bank
      && mem_o.addr == req_i.addr;
  endproperty
  a_direct_bank0: assert property (p_direct_bank0) else $error("Direct access left bank 0");

  property p_null_read;
    rd_en && (req_i.addr == dmau_pkg::ADDR_IND_A) && is_virtual(ptr_a_q)
      |=> rvalid_o && rdata_o == dmau_pkg::BYTE_ZERO;
  endproperty
  a_null_read: assert property (p_null_read) else $error("Null read not zero");

  property p_null_write;
    req_i.valid && req_i.we && (req_i.addr == dmau_pkg::ADDR_IND_B) && is_virtual(ptr_b_q)
      |-> !mem_o.req;
  endproperty
  a_null_write: assert property (p_null_write) else $error("Null write reached memory");

  property p_bank_read_zero;
    rd_en && local_hit && !loc.nul && (loc.addr == dmau_pkg::ADDR_BANK)
      |=> rdata_o[7:1] == 7'h00;
  endproperty
  a_bank_read_zero: assert property (p_bank_read_zero) else $error("Bank high bits set");

  property p_bank_soft_rst;
    soft_rst_i |=> bank_select_bit_o == dmau_pkg::BANK_RST;
  endproperty
  a_bank_soft_rst: assert property (p_bank_soft_rst) else $error("Bank kept on reset");

  property p_pcl_dummy;
    wr_en && local_hit && (loc.addr == dmau_pkg::ADDR_PCLO)
      |=> pc_load_o && dummy_cycle_o && pc_low_o == $past(wbyte) ##1 !dummy_cycle_o;
  endproperty
  a_pcl_dummy: assert property (p_pcl_dummy) else $error("Low PC write jump wrong");

  property p_tbl_high;
    req_i.valid && req_i.tbl |=> thb_q == $past(tword[15:8]);
  endproperty
  a_tbl_high: assert property (p_tbl_high) else $error("Table high byte lost");

  property p_unlock_start;
    unlock_ok |=> map_active_o;
  endproperty
  a_unlock_start: assert property (p_unlock_start) else $error("Unlock did not map");

  property p_no_lone_second;
    !map_active_o && !armed_q ##0 (instr_cycle_i && unlock_wr) |=> !map_active_o;
  endproperty
  a_no_lone_second: assert property (p_no_lone_second) else $error("Map without 55H");

  property p_wake_clear;
    wake_i |=> unlock_q == dmau_pkg::BYTE_ZERO;
  endproperty
  a_wake_clear: assert property (p_wake_clear) else $error("Unlock not cleared on wake");

  property p_alu_acc;
    alu_we_i |=> acc_o == $past(alu_result_i);
  endproperty
  a_alu_acc: assert property (p_alu_acc) else $error("ALU result not in accumulator");

  property p_opt_fetch;
    req_i.valid && req_i.tbl && map_active_o && page == '1
      && tplo_q[7:5] == dmau_pkg::OPT_WIN_TOP
      |-> opt_rd_o && !pm_rd_o;
  endproperty
  a_opt_fetch: assert property (p_opt_fetch) else $error("Option window missed");

  c_unlock:   cover property (unlock_ok);
  c_opt_read: cover property (opt_rd_o);
  c_bank1:    cover property (mem_o.req && mem_o.bank);
  c_pcl:      cover property (pc_load_o);

endmodule : dmau_core

// ---- shared/dmau_pkg.sv ----
// Shared constants and carrier types for the data memory addressing unit
package dmau_pkg;

  // ----------------------------------------------------------------------
  // Special register addresses in bank 0
  // ----------------------------------------------------------------------
  localparam logic [7:0] ADDR_IND_A  = 8'h00;  // virtual_indirect_reg_a
  localparam logic [7:0] ADDR_PTR_A  = 8'h01;  // pointer_a
  localparam logic [7:0] ADDR_IND_B  = 8'h02;  // virtual_indirect_reg_b
  localparam logic [7:0] ADDR_PTR_B  = 8'h03;  // pointer_b
  localparam logic [7:0] ADDR_BANK   = 8'h04;  // bank_select
  localparam logic [7:0] ADDR_ACC    = 8'h05;  // alu_result_register
  localparam logic [7:0] ADDR_PCLO   = 8'h06;  // program_counter_low
  localparam logic [7:0] ADDR_TPLO   = 8'h07;  // table_pointer_low
  localparam logic [7:0] ADDR_THB    = 8'h08;  // table_high_byte
  localparam logic [7:0] ADDR_TPHI   = 8'h09;  // table_pointer_high
  localparam logic [7:0] ADDR_UNLOCK = 8'h3F;  // option_map_unlock

  // ----------------------------------------------------------------------
  // Reset values, patterns and field positions
  // ----------------------------------------------------------------------
  localparam logic [7:0] BYTE_ZERO      = 8'h00;
  localparam logic       BANK_RST       = 1'b0;
  localparam logic [7:0] UNLOCK_FIRST   = 8'h55;
  localparam logic [7:0] UNLOCK_SECOND  = 8'hAA;
  localparam logic [2:0] OPT_WIN_TOP    = 3'h7;  // Low byte E0..FF has top bits set
  localparam int         OPT_AW         = 5;     // 32 option words
  localparam int         PM_DW          = 16;    // Program word width
  localparam int         PAGE_W_DEF     = 3;     // Program page bits above the low byte
  localparam int         MAP_LOW_SPEED_INTERNAL_OSC_PERIODS = 4;   // Mapping window length in slow periods
  localparam int         MAP_CNT_W      = 3;

  // ----------------------------------------------------------------------
  // Carriers
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic       valid;  // Executor presents an operand access
    logic       we;     // Write of wdata
    logic       tbl;    // Table read, low byte written to addr
    logic [7:0] addr;   // Operand address as coded in the instruction
    logic [7:0] wdata;
  } dmau_req_t;

  typedef struct packed {
    logic       req;
    logic       we;
    logic       bank;
    logic [7:0] addr;
    logic [7:0] wdata;
  } dmau_mem_t;

  typedef struct packed {
    logic       bank;
    logic [7:0] addr;
    logic       nul;    // Pointer aims at a virtual register
  } dmau_loc_t;

endpackage : dmau_pkg

// ---- src/dmau_map_timer.sv ----
// Option memory mapping window timer counted in slow oscillator periods
`timescale 1ns/1ns
module dmau_map_timer #(
  parameter int PERIODS = dmau_pkg::MAP_LOW_SPEED_INTERNAL_OSC_PERIODS
) (
  input  wire logic mclk_i,
  input  wire logic reset_n_i,
  input  wire logic start_i,     // Completed unlock sequence
  input  wire logic low_speed_internal_osc_tick_i, // One pulse per low_speed_internal_osc period
  output logic      active_o
);

  logic                          active_q, active_d;
  logic [dmau_pkg::MAP_CNT_W-1:0] cnt_q, cnt_d;

  // Restart wins over expiry so a fresh unlock always gets a full window
  always_comb begin
    active_d = active_q;
    cnt_d    = cnt_q;
    if (start_i) begin
      active_d = 1'b1;
      cnt_d    = '0;
    end else if (active_q && low_speed_internal_osc_tick_i) begin
      if (cnt_q == dmau_pkg::MAP_CNT_W'(PERIODS - 1)) begin
        active_d = 1'b0;
        cnt_d    = '0;
      end else begin
        cnt_d = cnt_q + 1'b1;
      end
    end
  end

  // State registers
  always_ff @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      active_q <= 1'b0;
      cnt_q    <= '0;
    end else begin
      active_q <= active_d;
      cnt_q    <= cnt_d;
    end
  end

  assign active_o = active_q;

endmodule : dmau_map_timer

// ---- tb/dmau_mem_model.sv ----
// Behavioural data, program and option memories facing the addressing unit
`timescale 1ns/1ns
module dmau_mem_model #(
  parameter int PAGE_W = 3
) (
  input  wire logic                mclk_i,
  input  wire dmau_pkg::dmau_mem_t mem_i,
  output logic [7:0]               mem_rdata_o,
  input  wire logic [PAGE_W+7:0]   pm_addr_i,
  output logic [15:0]              pm_data_o,
  input  wire logic [4:0]          opt_addr_i,
  output logic [15:0]              opt_data_o
);
  logic [7:0] ram [2][256];
  logic [7:0] idle_q = 8'h5A;

  // Unselected RAM shows a toggling pattern so a stale byte never passes
  assign mem_rdata_o = mem_i.req ? ram[mem_i.bank][mem_i.addr] : idle_q;
  // High byte carries the page, so a wrong page shows in the table-high byte
  assign pm_data_o  = {8'(8'h80 | 8'(pm_addr_i[PAGE_W+7:8])), pm_addr_i[7:0]};
  assign opt_data_o = {3'h5, opt_addr_i, 3'h3, opt_addr_i};

  // Two banks of RAM, cleared at start
  initial begin
    for (int b = 0; b < 2; b++) for (int a = 0; a < 256; a++) ram[b][a] = 8'h00;
  end

  always @(posedge mclk_i) begin
    idle_q <= ~idle_q;
    if (mem_i.req && mem_i.we) ram[mem_i.bank][mem_i.addr] <= mem_i.wdata;
  end
endmodule : dmau_mem_model

// ---- tb/dmau_core_tb.sv ----
// Self-checking testbench for the data memory addressing unit
`timescale 1ns/1ns
module dmau_core_tb;
  logic mclk_i = 1'b0, reset_n_i = 1'b0, soft_rst_i = 1'b0, wake_i = 1'b0;
  logic instr_cycle_i = 1'b1, low_speed_internal_osc_tick_i = 1'b0, alu_we_i = 1'b0, tbl_last_page_i = 1'b0;
  logic [7:0] alu_result_i = 8'h00, pc_low_i = 8'h00, rdata_o, acc_o, pc_low_o, mem_rdata_i;
  logic rvalid_o, pc_load_o, dummy_cycle_o, pm_rd_o, opt_rd_o, map_active_o, bank_select_bit_o;
  logic [10:0] pm_addr_o;
  logic [4:0] opt_addr_o;
  logic [15:0] pm_data_i, opt_data_i;
  dmau_pkg::dmau_req_t req_i = '0;
  dmau_pkg::dmau_mem_t mem_o;
  int err_count = 0;
  int checks = 0;

  always #25 mclk_i = ~mclk_i;

  dmau_core dmau_core_i (.mclk_i(mclk_i), .reset_n_i(reset_n_i), .soft_rst_i(soft_rst_i),
    .wake_i(wake_i), .instr_cycle_i(instr_cycle_i), .low_speed_internal_osc_tick_i(low_speed_internal_osc_tick_i), .req_i(req_i),
    .rdata_o(rdata_o), .rvalid_o(rvalid_o), .alu_we_i(alu_we_i), .alu_result_i(alu_result_i),
    .acc_o(acc_o), .pc_low_i(pc_low_i), .pc_load_o(pc_load_o), .pc_low_o(pc_low_o),
    .dummy_cycle_o(dummy_cycle_o), .tbl_last_page_i(tbl_last_page_i), .pm_rd_o(pm_rd_o),
    .pm_addr_o(pm_addr_o), .pm_data_i(pm_data_i), .opt_rd_o(opt_rd_o), .opt_addr_o(opt_addr_o),
    .opt_data_i(opt_data_i), .mem_o(mem_o), .mem_rdata_i(mem_rdata_i),
    .map_active_o(map_active_o), .bank_select_bit_o(bank_select_bit_o));

  dmau_mem_model dmau_mem_model_i (.mclk_i(mclk_i), .mem_i(mem_o), .mem_rdata_o(mem_rdata_i),
    .pm_addr_i(pm_addr_o), .pm_data_o(pm_data_i), .opt_addr_i(opt_addr_o),
    .opt_data_o(opt_data_i));

  // ----------------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------------
  task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
    checks++;
    if (g !== e) begin
      err_count++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, g);
    end
  endtask : chk

  // Idle cycles also drop every one-cycle pulse input
  task automatic idle(input int n);
    repeat (n) begin
      @(posedge mclk_i);
      req_i <= '0; alu_we_i <= 1'b0; low_speed_internal_osc_tick_i <= 1'b0; soft_rst_i <= 1'b0; wake_i <= 1'b0;
    end
  endtask : idle

  // Requests are not spaced, so two calls in a row are back to back
  task automatic put(input logic w, input logic t, input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk_i);
    req_i <= {1'b1, w, t, a, d};
  endtask : put

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    put(1'b1, 1'b0, a, d);
    idle(1);
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    put(1'b0, 1'b0, a, 8'h00);
    idle(1);
    #1;
    chk("rvalid", 16'h1, rvalid_o);
    chk("rdata", e, rdata_o);
  endtask : rd

  // Pattern goes out back to back with no other request between
  task automatic unlock();
    put(1'b1, 1'b0, dmau_pkg::ADDR_UNLOCK, 8'h55);
    put(1'b1, 1'b0, dmau_pkg::ADDR_UNLOCK, 8'hAA);
    idle(2);
  endtask : unlock

  task automatic tick(input int n);
    repeat (n) begin
      @(posedge mclk_i);
      low_speed_internal_osc_tick_i <= 1'b1;
      idle(2);
    end
    #1;
  endtask : tick

  // ----------------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------------
  task automatic t_bank();
    rd(dmau_pkg::ADDR_BANK, 8'h00);
    rd(dmau_pkg::ADDR_UNLOCK, 8'h00);
    wr(dmau_pkg::ADDR_BANK, 8'hFF);
    rd(dmau_pkg::ADDR_BANK, 8'h01);
    chk("bank_bit", 16'h1, bank_select_bit_o);
    wr(8'h80, 8'h11);
    wr(dmau_pkg::ADDR_PTR_B, 8'h80);
    rd(dmau_pkg::ADDR_PTR_B, 8'h80);
    wr(dmau_pkg::ADDR_IND_B, 8'h22);
    rd(8'h80, 8'h11);
    rd(dmau_pkg::ADDR_IND_B, 8'h22);
    wr(dmau_pkg::ADDR_PTR_A, 8'h80);
    rd(dmau_pkg::ADDR_IND_A, 8'h11);
    wr(dmau_pkg::ADDR_BANK, 8'h00);
    rd(dmau_pkg::ADDR_IND_B, 8'h11);
    wr(dmau_pkg::ADDR_PTR_A, dmau_pkg::ADDR_IND_B);
    wr(dmau_pkg::ADDR_IND_A, 8'h77);
    rd(dmau_pkg::ADDR_IND_A, 8'h00);
    rd(dmau_pkg::ADDR_PTR_B, 8'h80);
    wr(dmau_pkg::ADDR_BANK, 8'h01);
    @(posedge mclk_i) soft_rst_i <= 1'b1;
    idle(1);
    rd(dmau_pkg::ADDR_BANK, 8'h00);
  endtask : t_bank

  task automatic t_alu_pc();
    @(posedge mclk_i);
    alu_we_i <= 1'b1;
    alu_result_i <= 8'h3C;
    idle(1);
    #1 chk("acc", 16'h3C, acc_o);
    rd(dmau_pkg::ADDR_ACC, 8'h3C);
    pc_low_i <= 8'h47;
    rd(dmau_pkg::ADDR_PCLO, 8'h47);
    put(1'b1, 1'b0, dmau_pkg::ADDR_PCLO, 8'h9A);
    idle(1);
    #1 chk("pc_load", 16'h1, pc_load_o);
    chk("pc_low", 16'h9A, pc_low_o);
    chk("dummy", 16'h1, dummy_cycle_o);
    idle(1);
    #1 chk("pc_load_end", 16'h0, pc_load_o);
  endtask : t_alu_pc

  task automatic t_table();
    wr(dmau_pkg::ADDR_TPLO, 8'h12);
    wr(dmau_pkg::ADDR_TPHI, 8'h05);
    put(1'b0, 1'b1, 8'h90, 8'h00);
    #1 chk("pm_addr", 16'h0512, pm_addr_o);
    idle(1);
    rd(dmau_pkg::ADDR_THB, 8'h85);
    rd(8'h90, 8'h12);
  endtask : t_table

  task automatic t_map();
    wr(dmau_pkg::ADDR_TPLO, 8'hE3);
    @(posedge mclk_i) tbl_last_page_i <= 1'b1;
    unlock();
    #1 chk("map_on", 16'h1, map_active_o);
    put(1'b0, 1'b1, 8'h90, 8'h00);
    #1 chk("opt_rd", 16'h1, opt_rd_o);
    chk("opt_addr", 16'h03, opt_addr_o);
    idle(1);
    rd(dmau_pkg::ADDR_THB, 8'hA3);
    rd(8'h90, 8'h63);
    tick(3);
    chk("map_hold", 16'h1, map_active_o);
    tick(1);
    chk("map_off", 16'h0, map_active_o);
    put(1'b0, 1'b1, 8'h90, 8'h00);
    #1 chk("pm_rd", 16'h1, pm_rd_o);
    idle(1);
    unlock();
    tick(2);
    unlock();
    tick(3);
    chk("map_restart", 16'h1, map_active_o);
    tick(1);
    chk("map_end", 16'h0, map_active_o);
  endtask : t_map

  task automatic t_abort_wake();
    put(1'b1, 1'b0, dmau_pkg::ADDR_UNLOCK, 8'h55);
    idle(1);
    put(1'b1, 1'b0, dmau_pkg::ADDR_UNLOCK, 8'hAA);
    idle(2);
    #1 chk("map_abort", 16'h0, map_active_o);
    wr(dmau_pkg::ADDR_UNLOCK, 8'h12);
    rd(dmau_pkg::ADDR_UNLOCK, 8'h12);
    @(posedge mclk_i) wake_i <= 1'b1;
    idle(1);
    rd(dmau_pkg::ADDR_UNLOCK, 8'h00);
  endtask : t_abort_wake

  // ----------------------------------------------------------------------
  // Verdict, main sequence and watchdog
  // ----------------------------------------------------------------------
  task automatic results();
    if (err_count == 0 && checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : results

  initial begin
    repeat (5) @(posedge mclk_i);
    reset_n_i <= 1'b1;
    t_bank();
    t_alu_pc();
    t_table();
    t_map();
    t_abort_wake();
    results();
  end

  // The whole run needs under 150 cycles; this limit only catches a hang
  initial begin
    repeat (20000) @(posedge mclk_i);
    err_count++;
    results();
  end
endmodule : dmau_core_tb
